/* File: hdl/bss_consts.vh */
// Purpose: shared constants of the bit string setter execution unit
// Assumes: 32-bit operand registers, byte-wide memory port
// Notes: definitions only
`ifndef BSS_CONSTS_VH
`define BSS_CONSTS_VH
`define BSS_MAX_RUN 32'd25
`define BSS_LUT_BYTES 1024
`define BSS_LUT_IDX_W 10
`define BSS_ST_IDLE 3'h0
`define BSS_ST_LUT_RD 3'h1
`define BSS_ST_MEM_RD 3'h2
`define BSS_ST_MEM_WR 3'h3
`define BSS_ST_DONE 3'h4
`define BSS_OP_NONE 2'h0
`define BSS_OP_CONTIG 2'h1
`define BSS_OP_PERP 2'h2
`endif

/* File: hdl/bss_bit_string_setter.v */
// Purpose: executes the contiguous-set and perpendicular-set bit string operations
// Assumes: byte-wide memory with one-cycle-or-more handshake via mem_ack_in
// Notes: contiguous runs are formed from a 1k-byte table: entry 32*len+firstbit
//        gives the byte mask for bits firstbit.. of that byte, run length len
//
// Overview of operation
// RQ1 - contiguous set writes a run of ones starting at base plus offset
// RQ2 - contiguous set reads offset as signed and count as unsigned
// RQ3 - contiguous set fetches byte patterns from a 1k-byte table at aux
// RQ4 - count at most 25 clears the flag and sets the bits
// RQ5 - count above 25 sets the flag and does nothing else
// RQ6 - contiguous set leaves every operand register unchanged
// RQ7 - perpendicular set starts at byte address base combined with offset
// RQ8 - perpendicular set uses aux as a signed warp in bits
// RQ9 - set first bit, then add warp and set next, until count set
// RQ10 - perpendicular set ends with offset final, count zero, base and aux kept
// RQ11 - every bit set is a read-modify-write; neighbouring bits keep values
// RQ12 - bit address is byte address times eight plus signed offset, bit0 lsb
`timescale 1ns/1ps
`default_nettype none
`include "bss_consts.vh"
module bss_bit_string_setter (
  // clock and reset
  input wire ref_clk_in,
  input wire resetn_in,
  // operation start and operands
  input wire contig_start_in,
  input wire perp_start_in,
  input wire [31:0] base_address_in,
  input wire [31:0] bit_offset_in,
  input wire [31:0] bit_count_in,
  input wire [31:0] aux_operand_in,
  // memory port
  output reg mem_req_out,
  output reg mem_we_out,
  output reg [31:0] mem_addr_out,
  output reg [7:0] mem_wdata_out,
  input wire [7:0] mem_rdata_in,
  input wire mem_ack_in,
  // results
  output reg busy_out,
  output reg done_out,
  output reg status_flag_out,
  output reg [31:0] base_address_out,
  output reg [31:0] bit_offset_out,
  output reg [31:0] bit_count_out,
  output reg [31:0] aux_operand_out
);
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;
  reg [2:0] state_reg;
  reg [1:0] op_reg;
  reg [31:0] base_address_reg;
  reg [31:0] bit_offset_reg;
  reg [31:0] bit_count_reg;
  reg [31:0] aux_operand_reg;
  reg [31:0] cur_off_reg; // working signed bit offset
  reg [31:0] left_reg; // bits still to set
  reg [7:0] mask_reg;
  reg [3:0] chunk_reg; // bits covered by current contiguous byte
  wire [31:0] bit_addr;
  wire [2:0] first_bit;
  wire [3:0] room;
  wire [3:0] take;

  // byte address times eight plus signed offset
  function [31:0] bss_bit_addr;
    input [31:0] byte_addr;
    input [31:0] off;
    begin
      bss_bit_addr = {byte_addr[28:0], 3'h0} + off; // RQ12
    end
  endfunction

  // byte that holds a bit address; bit zero is the lsb of that byte
  function [31:0] bss_byte_of;
    input [31:0] bit_address;
    begin
      bss_byte_of = {3'h0, bit_address[31:3]}; // RQ12
    end
  endfunction

  // reset release through two flip-flops
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // address of the bit being worked on
  assign bit_addr = bss_bit_addr(base_address_reg, cur_off_reg); // RQ1 RQ7
  assign first_bit = bit_addr[2:0];
  assign room = 4'h8 - {1'b0, first_bit};
  assign take = (left_reg < {28'h0, room}) ? left_reg[3:0] : room;

  // sequencer
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `BSS_ST_IDLE;
      op_reg <= `BSS_OP_NONE;
      base_address_reg <= 32'h0;
      bit_offset_reg <= 32'h0;
      bit_count_reg <= 32'h0;
      aux_operand_reg <= 32'h0;
      cur_off_reg <= 32'h0;
      left_reg <= 32'h0;
      mask_reg <= 8'h0;
      chunk_reg <= 4'h0;
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_addr_out <= 32'h0;
      mem_wdata_out <= 8'h0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      status_flag_out <= 1'b0;
      base_address_out <= 32'h0;
      bit_offset_out <= 32'h0;
      bit_count_out <= 32'h0;
      aux_operand_out <= 32'h0;
    end else begin
      done_out <= 1'b0;
      case (state_reg)
        // wait for a start, latch operands and judge the run length
        `BSS_ST_IDLE: begin
          if (contig_start_in || perp_start_in) begin
            base_address_reg <= base_address_in;
            bit_offset_reg <= bit_offset_in;
            bit_count_reg <= bit_count_in;
            aux_operand_reg <= aux_operand_in;
            cur_off_reg <= bit_offset_in; // RQ2
            left_reg <= bit_count_in;
            busy_out <= 1'b1;
            if (contig_start_in) begin
              op_reg <= `BSS_OP_CONTIG;
              if (bit_count_in > `BSS_MAX_RUN) begin
                status_flag_out <= 1'b1; // RQ5
                state_reg <= `BSS_ST_DONE;
              end else begin
                status_flag_out <= 1'b0; // RQ4
                state_reg <= `BSS_ST_MEM_RD;
              end
            end else begin
              op_reg <= `BSS_OP_PERP;
              state_reg <= `BSS_ST_MEM_RD;
            end
          end
        end
        // issue the next table or byte read, or finish when nothing is left
        `BSS_ST_MEM_RD: begin
          if (left_reg == 32'h0) begin
            state_reg <= `BSS_ST_DONE;
          end else if (op_reg == `BSS_OP_CONTIG) begin
            // pattern byte from table: index 32*len + first bit
            chunk_reg <= take;
            mem_req_out <= 1'b1;
            mem_we_out <= 1'b0;
            mem_addr_out <= aux_operand_reg + {23'h0, take[3:0], 2'h0, first_bit}; // RQ3
            state_reg <= `BSS_ST_LUT_RD;
          end else begin
            chunk_reg <= 4'h1;
            mask_reg <= 8'h1 << first_bit;
            mem_req_out <= 1'b1;
            mem_we_out <= 1'b0;
            mem_addr_out <= bss_byte_of(bit_addr); // RQ11
            state_reg <= `BSS_ST_MEM_WR;
          end
        end
        // take the pattern byte, then keep the request up for the target byte
        `BSS_ST_LUT_RD: begin
          if (mem_ack_in && mem_req_out && !mem_we_out) begin
            mask_reg <= mem_rdata_in;
            mem_addr_out <= bss_byte_of(bit_addr); // RQ11
            state_reg <= `BSS_ST_MEM_WR;
          end
        end
        // read answered: write back merged byte; write answered: advance
        `BSS_ST_MEM_WR: begin
          if (mem_ack_in && mem_req_out) begin
            if (!mem_we_out) begin
              mem_we_out <= 1'b1;
              mem_wdata_out <= mem_rdata_in | mask_reg; // RQ11
            end else begin
              mem_req_out <= 1'b0;
              mem_we_out <= 1'b0;
              left_reg <= left_reg - {28'h0, chunk_reg};
              if (op_reg == `BSS_OP_CONTIG) begin
                cur_off_reg <= cur_off_reg + {28'h0, chunk_reg}; // RQ1
              end else if (left_reg != 32'h1) begin
                cur_off_reg <= cur_off_reg + aux_operand_reg; // RQ8 RQ9
              end
              state_reg <= `BSS_ST_MEM_RD;
            end
          end
        end
        // publish results for one done pulse and return to idle
        `BSS_ST_DONE: begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          base_address_out <= base_address_reg;
          aux_operand_out <= aux_operand_reg;
          if (op_reg == `BSS_OP_PERP) begin
            bit_offset_out <= cur_off_reg; // RQ10
            bit_count_out <= 32'h0;
          end else begin
            bit_offset_out <= bit_offset_reg; // RQ6
            bit_count_out <= bit_count_reg;
          end
          state_reg <= `BSS_ST_IDLE;
        end
        default: begin
          state_reg <= `BSS_ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: verif/bss_props.sv */
// Purpose: port checker for the bit string setter
// Assumes: one clock domain
// Notes: bound to bss_bit_string_setter by the bind statement below
`timescale 1ns/1ps
`default_nettype none
module bss_props (
  input wire logic ref_clk_in, resetn_in, contig_start_in, perp_start_in,
  input wire logic [31:0] base_address_in, bit_offset_in, bit_count_in, aux_operand_in,
  input wire logic mem_req_out, mem_we_out, mem_ack_in, busy_out, done_out, status_flag_out,
  input wire logic [7:0] mem_wdata_out, mem_rdata_in,
  input wire logic [31:0] mem_addr_out, base_address_out, bit_offset_out, bit_count_out,
  input wire logic [31:0] aux_operand_out
);
  logic go;
  logic lc;
  logic [31:0] lb, lo, ln, la;
  logic [7:0] rd_q;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  assign go = (contig_start_in | perp_start_in) & !busy_out;
  // operands of the last accepted start and the last byte read
  always @(posedge ref_clk_in) begin
    if (go) {lc, lb, lo, ln, la} <= {contig_start_in, base_address_in, bit_offset_in,
      bit_count_in, aux_operand_in};
    if (mem_req_out & mem_ack_in & !mem_we_out) rd_q <= mem_rdata_in;
  end
  property p_big; go & contig_start_in & bit_count_in > 32'd25 |-> ##[1:3] done_out & status_flag_out; endproperty
  a_big: assert property (p_big) else $error("long run not flagged");
  property p_quiet; go & contig_start_in & bit_count_in > 32'd25 |=> !mem_req_out [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("long run touched memory");
  property p_flag; done_out & lc |-> status_flag_out == (ln > 32'd25); endproperty
  a_flag: assert property (p_flag) else $error("flag wrong at done");
  property p_keep; done_out & lc |-> {base_address_out, bit_offset_out, bit_count_out,
    aux_operand_out} == {lb, lo, ln, la}; endproperty
  a_keep: assert property (p_keep) else $error("operand changed");
  property p_perp; done_out & !lc |-> bit_count_out == 0 && {base_address_out,
    aux_operand_out} == {lb, la}; endproperty
  a_perp: assert property (p_perp) else $error("perpendicular results wrong");
  property p_hold; mem_req_out & !mem_ack_in |=> mem_req_out & $stable(mem_addr_out) & $stable(mem_we_out); endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_rmw; mem_req_out & mem_we_out |-> (mem_wdata_out & rd_q) == rd_q; endproperty
  a_rmw: assert property (p_rmw) else $error("neighbour bit lost");
  property p_one; mem_req_out & mem_we_out & !lc |-> $onehot0(mem_wdata_out ^ rd_q); endproperty
  a_one: assert property (p_one) else $error("more than one bit set");
  // main scenarios
  c_big: cover property (go & contig_start_in & bit_count_in > 32'd25);
  c_perp: cover property (done_out & !lc);
  c_wr: cover property (mem_req_out & mem_we_out & mem_ack_in);
endmodule
bind bss_bit_string_setter bss_props i_props (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
  .contig_start_in(contig_start_in), .perp_start_in(perp_start_in),
  .base_address_in(base_address_in), .bit_offset_in(bit_offset_in),
  .bit_count_in(bit_count_in), .aux_operand_in(aux_operand_in), .mem_req_out(mem_req_out),
  .mem_we_out(mem_we_out), .mem_ack_in(mem_ack_in), .busy_out(busy_out), .done_out(done_out),
  .status_flag_out(status_flag_out), .mem_wdata_out(mem_wdata_out),
  .mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out),
  .base_address_out(base_address_out), .bit_offset_out(bit_offset_out),
  .bit_count_out(bit_count_out), .aux_operand_out(aux_operand_out));
`default_nettype wire

/* File: verif/bss_mem.sv */
// Purpose: byte memory on the far side
// Assumes: one ack per request
// Notes: read data toggles outside acks
`timescale 1ns/1ps
`default_nettype none
module bss_mem (
  input wire logic clk_in, req_in, we_in,
  input wire logic [31:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic ack_out
);
  logic [7:0] mem [0:2047];
  initial ack_out = 1'b0;
  initial rdata_out = 8'h00;
  // answer each pending request one cycle later
  always @(posedge clk_in) begin
    ack_out <= req_in & !ack_out;
    rdata_out <= (req_in & !ack_out & !we_in) ? mem[addr_in[10:0]] : ~rdata_out;
    if (req_in & !ack_out & we_in) mem[addr_in[10:0]] <= wdata_in;
  end
endmodule
`default_nettype wire

/* File: verif/bit_string_setter_test.sv */
// Purpose: self-checking bench for the bit string setter
// Assumes: data bytes 0-3ff, run table at 400
// Notes: shadow memory predicts every data byte
`timescale 1ns/1ps
`default_nettype none
module bit_string_setter_test;
  logic clk = 0, rn = 0, cs = 0, ps = 0, rq, we, ak, by, dn, fl;
  logic [31:0] b = 0, o = 0, n = 0, a = 0, ad, bo, oo, no, ao;
  logic [7:0] wd, rd, em [0:1023];
  int n_fail = 0, total_checks = 0;
  bss_bit_string_setter i_dut (.ref_clk_in(clk), .resetn_in(rn), .contig_start_in(cs),
    .perp_start_in(ps), .base_address_in(b), .bit_offset_in(o), .bit_count_in(n),
    .aux_operand_in(a), .mem_req_out(rq), .mem_we_out(we), .mem_addr_out(ad),
    .mem_wdata_out(wd), .mem_rdata_in(rd), .mem_ack_in(ak), .busy_out(by), .done_out(dn),
    .status_flag_out(fl), .base_address_out(bo), .bit_offset_out(oo), .bit_count_out(no),
    .aux_operand_out(ao));
  bss_mem i_mem (.clk_in(clk), .req_in(rq), .we_in(we), .addr_in(ad), .wdata_in(wd),
    .rdata_out(rd), .ack_out(ak));
  initial forever #2 clk = ~clk;
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one operation: predict, start, wait for done, compare
  task automatic run(logic c, logic [31:0] bb, ob, nb, ab, logic ef);
    logic [31:0] p;
    int k;
    p = bb * 8 + ob;
    for (k = 0; k < nb && !(c && nb > 25); k++) begin
      em[p[12:3]] |= 8'h01 << p[2:0];
      p += c ? 32'd1 : ab;
    end
    @(posedge clk);
    {cs, ps, b, o, n, a} <= {c, !c, bb, ob, nb, ab};
    @(posedge clk);
    {cs, ps} <= 2'b00;
    @(negedge clk);
    chk("busy", 1, by);
    for (k = 0; k < 2000 && dn !== 1'b1; k++) @(negedge clk);
    chk("done", 1, dn);
    chk("idle", 0, by);
    chk("flag", ef, fl);
    chk("base", bb, bo);
    chk("aux", ab, ao);
    chk("count", c ? nb : 0, no);
    chk("offset", (c || nb == 0) ? ob : ob + (nb - 1) * ab, oo);
    for (k = 0; k < 1024; k++) chk("byte", em[k], i_mem.mem[k]);
  endtask
  // long contiguous run: flag only, memory untouched
  task automatic t_long_run();
    run(1, 32'h30, 0, 26, 32'h400, 1);
  endtask
  // perpendicular run with a negative warp
  task automatic t_perp_warp();
    run(0, 32'h40, 3, 5, -32'sd17, 1);
  endtask
  // perpendicular run of no bits
  task automatic t_perp_none();
    run(0, 32'h48, 6, 0, 32'd9, 1);
  endtask
  // contiguous run at the longest accepted length
  task automatic t_contig_full();
    run(1, 32'h20, 5, 25, 32'h400, 0);
  endtask
  // contiguous run from a negative offset
  task automatic t_contig_back();
    run(1, 32'h10, -32'sd3, 12, 32'h400, 0);
  endtask
  initial begin
    for (int k = 0; k < 2048; k++) i_mem.mem[k] = k < 1024 ? 8'h24 : 8'h00;
    for (int l = 1; l < 9; l++) for (int f = 0; f < 8; f++)
      i_mem.mem[1024 + 32 * l + f] = 8'hff >> (8 - l) << f;
    for (int k = 0; k < 1024; k++) em[k] = 8'h24;
    repeat (8) @(posedge clk);
    rn <= 1'b1;
    repeat (3) @(posedge clk);
    t_long_run();
    t_perp_warp();
    t_perp_none();
    t_contig_full();
    t_contig_back();
    end_sim();
  end
  // watchdog
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
